// File: rtl/qdr_device.sv
// Device end: serial frame decode, register bank, readback and status
//
// Chosen here: the serial register port and the address map.
`timescale 1ns/100ps
module qdr_device #(
   parameter int N_REGS = qdr_pkg::N_REGS
) (
   input wire logic hclk,
   input wire logic hresetn,
   qdr_link_if.dev link,
   input wire logic [3:0] limit_event,
   input wire logic [3:0] current_mode,
   input wire logic [3:0] vout_fault,
   input wire logic [3:0] iout_fault,
   input wire logic overheat,
   input wire logic [3:0] ramp_busy,
   input wire logic chip_addr_hi,
   input wire logic chip_addr_lo,
   output logic fault_alarm_n,
   output logic [3:0] ramp_enable
);
   logic [2:0] sclk_sync_reg;
   logic [2:0] sync_sync_reg;
   logic [1:0] din_sync_reg;
   logic [1:0] ahi_sync_reg;
   logic [1:0] alo_sync_reg;
   logic [1:0] chip_addr_reg;
   logic [15:0] regs [N_REGS];
   logic [31:0] rx_shift_reg;
   logic [5:0] bit_cnt_reg;
   logic [31:0] tx_shift_reg;
   logic sdo_reg;
   logic pending_reg;
   logic [4:0] pending_sel_reg;
   logic check_err_reg;
   logic [15:0] status_reg;
   logic [15:0] status_next;
   logic sclk_rise;
   logic sclk_fall;
   logic frame_start;
   logic frame_end;
   logic in_frame;
   logic frame_check;
   logic status_on_write;
   logic [5:0] expect_bits;
   logic [23:0] rx_word;
   logic crc_ok;
   logic addr_ok;
   logic [4:0] rx_sel;
   logic write_ok;
   logic [15:0] out_data;
   logic [23:0] out_word;
   logic [31:0] out_load;

   // Link pins pass two flops; edges seen between second and third
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sclk_sync_reg <= 3'h0;
         sync_sync_reg <= 3'h7;
         din_sync_reg <= 2'h0;
         ahi_sync_reg <= 2'h0;
         alo_sync_reg <= 2'h0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], link.sclk};
         sync_sync_reg <= {sync_sync_reg[1:0], link.sync_n};
         din_sync_reg <= {din_sync_reg[0], link.sdin};
         ahi_sync_reg <= {ahi_sync_reg[0], chip_addr_hi};
         alo_sync_reg <= {alo_sync_reg[0], chip_addr_lo};
      end
   end

   // Address straps re-registered every cycle after release of reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chip_addr_reg <= 2'h0;
      end else begin
         chip_addr_reg <= {ahi_sync_reg[1], alo_sync_reg[1]};
      end
   end

   assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
   assign frame_start = ~sync_sync_reg[1] & sync_sync_reg[2];
   assign frame_end = sync_sync_reg[1] & ~sync_sync_reg[2];
   assign in_frame = ~sync_sync_reg[1];

   assign frame_check = regs[qdr_pkg::SEL_MAIN][qdr_pkg::MAIN_FRAME_CHECK];
   assign status_on_write =
      regs[qdr_pkg::SEL_MAIN][qdr_pkg::MAIN_STATUS_ON_WRITE];
   assign expect_bits = frame_check ? 6'(qdr_pkg::LONG_BITS) :
      6'(qdr_pkg::FRAME_BITS);

   // Received word and its check
   assign rx_word = frame_check ? rx_shift_reg[31:8] : rx_shift_reg[23:0];
   assign crc_ok = !frame_check ||
      (qdr_pkg::crc8(rx_word) == rx_shift_reg[7:0]);
   assign addr_ok = (rx_word[qdr_pkg::ADDR_HI_BIT:qdr_pkg::ADDR_LO_BIT]
      == chip_addr_reg);
   assign rx_sel = rx_word[qdr_pkg::SEL_MSB:qdr_pkg::SEL_LSB];

   // Status is never a write target; slew words need fixed top bits
   always_comb begin
      write_ok = (rx_sel < 5'(N_REGS)) && (rx_sel != qdr_pkg::SEL_STATUS);
      if (rx_sel[4:2] == qdr_pkg::SEL_SLEW_BASE[4:2]) begin
         write_ok = write_ok && (rx_word[15:qdr_pkg::SLEW_FIXED_LSB]
            == qdr_pkg::SLEW_FIXED);
      end
   end

   // Live status word
   always_comb begin
      status_next = 16'h0000;
      status_next[qdr_pkg::ST_LIMIT_LSB +: 4] = limit_event;
      status_next[qdr_pkg::ST_CHECK_EN] = frame_check;
      status_next[qdr_pkg::ST_CHECK_ERR] = check_err_reg;
      status_next[qdr_pkg::ST_RAMP] = |(ramp_busy & ramp_enable);
      status_next[qdr_pkg::ST_HOT] = overheat;
      status_next[qdr_pkg::ST_VFAULT_LSB +: 4] = vout_fault;
      status_next[qdr_pkg::ST_IFAULT_LSB +: 4] =
         iout_fault | (limit_event & current_mode);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_reg <= qdr_pkg::REG_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   // Alarm from faults only, never from converter limit flags
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_alarm_n <= 1'b1;
      end else begin
         fault_alarm_n <= ~(|vout_fault | |iout_fault | overheat |
            check_err_reg);
      end
   end

   // Register selected for the outgoing frame
   always_comb begin
      out_data = 16'h0000;
      if (pending_reg) begin
         if (pending_sel_reg == qdr_pkg::SEL_STATUS) begin
            out_data = status_reg;
         end else if (pending_sel_reg < 5'(N_REGS)) begin
            out_data = regs[pending_sel_reg];
         end
      end else if (status_on_write) begin
         out_data = status_reg;
      end
   end

   assign out_word = {8'h00, out_data};
   assign out_load = frame_check ? {out_word, qdr_pkg::crc8(out_word)} :
      {out_word, 8'h00};

   // Receive shifter, sampled on rising serial clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_shift_reg <= 32'h0000_0000;
         bit_cnt_reg <= 6'h00;
      end else if (frame_start) begin
         rx_shift_reg <= 32'h0000_0000;
         bit_cnt_reg <= 6'h00;
      end else if (in_frame && sclk_rise) begin
         rx_shift_reg <= {rx_shift_reg[30:0], din_sync_reg[1]};
         if (bit_cnt_reg != 6'h3f) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
         end
      end
   end

   // Transmit shifter: first bit at frame start, next on falling clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_shift_reg <= 32'h0000_0000;
         sdo_reg <= 1'b0;
      end else if (frame_start) begin
         sdo_reg <= out_load[31];
         tx_shift_reg <= {out_load[30:0], 1'b0};
      end else if (in_frame && sclk_fall) begin
         sdo_reg <= tx_shift_reg[31];
         tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
      end
   end

   assign link.sdo = sdo_reg;

   // Frame completion: read latch, check error, register writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pending_reg <= 1'b0;
         pending_sel_reg <= 5'h00;
         check_err_reg <= 1'b0;
      end else if (frame_end) begin
         pending_reg <= 1'b0;
         if (bit_cnt_reg == expect_bits) begin
            check_err_reg <= ~crc_ok;
            if (crc_ok && addr_ok && rx_word[qdr_pkg::RW_BIT]) begin
               pending_reg <= 1'b1;
               pending_sel_reg <= rx_sel;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < N_REGS; i++) begin
            regs[i] <= qdr_pkg::REG_RESET;
         end
      end else if (frame_end && bit_cnt_reg == expect_bits && crc_ok &&
            addr_ok && !rx_word[qdr_pkg::RW_BIT] && write_ok) begin
         regs[rx_sel] <= rx_word[15:0];
      end
   end

   // Per-channel ramp enables from the slew registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ramp_enable <= 4'h0;
      end else begin
         for (int ch = 0; ch < 4; ch++) begin
            ramp_enable[ch] <= regs[qdr_pkg::SEL_SLEW_BASE + 5'(ch)]
               [qdr_pkg::SLEW_EN_BIT];
         end
      end
   end
endmodule : qdr_device

// File: inc/qdr_pkg.sv
// Shared constants, fields and check code for the readback link
package qdr_pkg;
   localparam int FRAME_BITS = 24;
   localparam int CHECK_BITS = 8;
   localparam int LONG_BITS = FRAME_BITS + CHECK_BITS;
   localparam int DATA_W = 16;
   localparam int N_REGS = 27;
   localparam int RW_BIT = 23;
   localparam int ADDR_HI_BIT = 22;
   localparam int ADDR_LO_BIT = 21;
   localparam int SEL_MSB = 20;
   localparam int SEL_LSB = 16;
   localparam logic [4:0] SEL_CLEAR_BASE = 5'h10;
   localparam logic [4:0] SEL_SLEW_BASE = 5'h14;
   localparam logic [4:0] SEL_STATUS = 5'h18;
   localparam logic [4:0] SEL_MAIN = 5'h19;
   localparam logic [4:0] SEL_SUPPLY = 5'h1a;
   localparam logic [23:0] NO_OPERATION_WORD = 24'h3c_e000;
   localparam logic [2:0] SLEW_FIXED = 3'h0;
   localparam int SLEW_FIXED_LSB = 13;
   localparam int SLEW_EN_BIT = 12;
   localparam int SLEW_CLK_LSB = 3;
   localparam int SLEW_STEP_LSB = 0;
   localparam int ST_LIMIT_LSB = 12;
   localparam int ST_CHECK_EN = 11;
   localparam int ST_CHECK_ERR = 10;
   localparam int ST_RAMP = 9;
   localparam int ST_HOT = 8;
   localparam int ST_VFAULT_LSB = 4;
   localparam int ST_IFAULT_LSB = 0;
   localparam int MAIN_STATUS_ON_WRITE = 11;
   localparam int MAIN_FRAME_CHECK = 12;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [31:0] HOST_TX_OFS = 32'h0000_0000;
   localparam logic [31:0] HOST_CFG_OFS = 32'h0000_0004;
   localparam logic [31:0] HOST_RX_OFS = 32'h0000_0008;
   localparam logic [31:0] HOST_STAT_OFS = 32'h0000_000c;
   localparam int CFG_CHECK_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_CRC_ERR_BIT = 1;
   localparam int CLK_NS = 50;
   localparam int SCLK_HALF_NS = 200;
   localparam int SCLK_HALF_CYC = SCLK_HALF_NS / CLK_NS;

   // CRC-8 over a 24-bit word, msb first
   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         if (c[7] ^ d[i]) begin
            c = {c[6:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction : crc8
endpackage : qdr_pkg

// File: inc/qdr_link_if.sv
// Serial link between the host controller and the converter device
`timescale 1ns/100ps
interface qdr_link_if;
   logic sclk;
   logic sync_n;
   logic sdin;
   logic sdo;
   modport dev(input sclk, input sync_n, input sdin, output sdo);
   modport host(output sclk, output sync_n, output sdin, input sdo);
endinterface : qdr_link_if

// File: rtl/qdr_host.sv
// Host end: AHB-Lite command registers driving serial frames
`timescale 1ns/100ps
module qdr_host #(
   parameter int SCLK_HALF = qdr_pkg::SCLK_HALF_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   qdr_link_if.host link
);
   typedef enum logic [4:0] {
      QDR_IDLE = 5'b00001,
      QDR_START = 5'b00010,
      QDR_LOW = 5'b00100,
      QDR_HIGH = 5'b01000,
      QDR_END = 5'b10000
   } qdr_hstate_t;

   qdr_hstate_t state_reg;
   logic ph_valid_reg;
   logic ph_write_reg;
   logic [31:0] ph_addr_reg;
   logic [23:0] tx_word_reg;
   logic check_cfg_reg;
   logic [31:0] rx_data_reg;
   logic crc_err_reg;
   logic go;
   logic [7:0] div_reg;
   logic tick;
   logic [31:0] tx_shift_reg;
   logic [31:0] rx_shift_reg;
   logic [5:0] bit_cnt_reg;
   logic sclk_reg;
   logic sync_n_reg;
   logic sdin_reg;
   logic sdo_s1_reg;
   logic sdo_s2_reg;
   logic [5:0] last_bit;

   // Bus slave: reads take one wait state, writes none
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid_reg <= 1'b0;
         ph_write_reg <= 1'b0;
         ph_addr_reg <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (hready) begin
            ph_valid_reg <= hsel & htrans[1];
            ph_write_reg <= hwrite;
            ph_addr_reg <= haddr;
            hreadyout <= ~(hsel & htrans[1] & ~hwrite);
         end else if (ph_valid_reg && !ph_write_reg && !hreadyout) begin
            hreadyout <= 1'b1;
            case (ph_addr_reg)
               qdr_pkg::HOST_TX_OFS: hrdata <= {8'h00, tx_word_reg};
               qdr_pkg::HOST_CFG_OFS: hrdata <= {31'h0, check_cfg_reg};
               qdr_pkg::HOST_RX_OFS: hrdata <= rx_data_reg;
               qdr_pkg::HOST_STAT_OFS: hrdata <= {30'h0, crc_err_reg,
                  state_reg != QDR_IDLE};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign go = hready && ph_valid_reg && ph_write_reg &&
      ph_addr_reg == qdr_pkg::HOST_TX_OFS && state_reg == QDR_IDLE;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_word_reg <= 24'h00_0000;
         check_cfg_reg <= 1'b0;
      end else if (hready && ph_valid_reg && ph_write_reg) begin
         if (go) begin
            tx_word_reg <= hwdata[23:0];
         end
         if (ph_addr_reg == qdr_pkg::HOST_CFG_OFS) begin
            check_cfg_reg <= hwdata[qdr_pkg::CFG_CHECK_BIT];
         end
      end
   end

   // Half-period divider for the serial clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_reg <= 8'h00;
      end else if (div_reg == 8'(SCLK_HALF - 1)) begin
         div_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end

   assign tick = (div_reg == 8'(SCLK_HALF - 1));
   assign last_bit = check_cfg_reg ? 6'(qdr_pkg::LONG_BITS - 1) :
      6'(qdr_pkg::FRAME_BITS - 1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sdo_s1_reg <= 1'b0;
         sdo_s2_reg <= 1'b0;
      end else begin
         sdo_s1_reg <= link.sdo;
         sdo_s2_reg <= sdo_s1_reg;
      end
   end

   // Frame sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= QDR_IDLE;
         sclk_reg <= 1'b0;
         sync_n_reg <= 1'b1;
         sdin_reg <= 1'b0;
         tx_shift_reg <= 32'h0000_0000;
         rx_shift_reg <= 32'h0000_0000;
         bit_cnt_reg <= 6'h00;
         rx_data_reg <= 32'h0000_0000;
         crc_err_reg <= 1'b0;
      end else begin
         case (state_reg)
            QDR_IDLE: begin
               if (go) begin
                  tx_shift_reg <= check_cfg_reg ?
                     {hwdata[23:0], qdr_pkg::crc8(hwdata[23:0])} :
                     {hwdata[23:0], 8'h00};
                  state_reg <= QDR_START;
               end
            end
            QDR_START: begin
               if (tick) begin
                  sync_n_reg <= 1'b0;
                  sdin_reg <= tx_shift_reg[31];
                  rx_shift_reg <= 32'h0000_0000;
                  bit_cnt_reg <= 6'h00;
                  state_reg <= QDR_LOW;
               end
            end
            QDR_LOW: begin
               if (tick) begin
                  sclk_reg <= 1'b1;
                  state_reg <= QDR_HIGH;
               end
            end
            QDR_HIGH: begin
               if (tick) begin
                  sclk_reg <= 1'b0;
                  // Sample at end of high half: device bit lags five cycles
                  rx_shift_reg <= {rx_shift_reg[30:0], sdo_s2_reg};
                  tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
                  sdin_reg <= tx_shift_reg[30];
                  bit_cnt_reg <= bit_cnt_reg + 6'h01;
                  state_reg <= (bit_cnt_reg == last_bit) ? QDR_END : QDR_LOW;
               end
            end
            QDR_END: begin
               if (tick) begin
                  sync_n_reg <= 1'b1;
                  sdin_reg <= 1'b0;
                  rx_data_reg <= rx_shift_reg;
                  crc_err_reg <= check_cfg_reg &&
                     qdr_pkg::crc8(rx_shift_reg[31:8]) != rx_shift_reg[7:0];
                  state_reg <= QDR_IDLE;
               end
            end
            default: state_reg <= QDR_IDLE;
         endcase
      end
   end

   assign link.sclk = sclk_reg;
   assign link.sync_n = sync_n_reg;
   assign link.sdin = sdin_reg;
endmodule : qdr_host

// File: sim/qdr_link_properties.sv
// Wire-level checks on the serial readback link between host and device
`timescale 1ns/100ps
module qdr_link_properties (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sclk,
   input wire logic sync_n,
   input wire logic sdin,
   input wire logic sdo
);
   logic [5:0] nbits_reg;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Serial clock rises seen in the current frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nbits_reg <= 6'h00;
      end else if (sync_n) begin
         nbits_reg <= 6'h00;
      end else if ($rose(sclk)) begin
         nbits_reg <= nbits_reg + 6'h01;
      end
   end

   sequence s_high_half;
      sclk [*4] ##1 !sclk;
   endsequence

   sequence s_lead_in;
      !sclk [*3] ##[1:6] sclk;
   endsequence

   a_sclk_idle_low: assert property (sync_n |-> !sclk)
      else $error("serial clock active outside a frame");
   a_lead_in_time: assert property ($fell(sync_n) |-> s_lead_in)
      else $error("first serial clock edge out of place");
   a_high_phase: assert property ($rose(sclk) |-> s_high_half)
      else $error("serial clock high phase not four cycles");
   a_low_phase: assert property ($fell(sclk) |-> !sclk [*4])
      else $error("serial clock low phase too short");
   a_sdin_held: assert property (sclk |-> $stable(sdin))
      else $error("input data moved while clock high");
   a_sdo_held: assert property (sclk |-> $stable(sdo))
      else $error("output data moved while clock high");
   a_frame_gap: assert property ($rose(sync_n) |-> sync_n [*4])
      else $error("frames too close together");
   a_frame_length: assert property ($rose(sync_n) |->
      (nbits_reg == 6'h18) || (nbits_reg == 6'h20))
      else $error("frame length neither 24 nor 32 bits");
   a_bits_capped: assert property (!sync_n |-> nbits_reg <= 6'h20)
      else $error("frame ran past 32 bits");
endmodule : qdr_link_properties

// File: sim/tb_top.sv
// Self-checking bench joining host and device across the serial link
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
   $display("wrong value at %0t ns: got %h expected %h", $time, g, e); end end
module tb_top;
   localparam logic [1:0] ADR = 2'h1;
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic hsel = 1'h0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [3:0] limit_event = 4'h0;
   logic [3:0] current_mode = 4'h0;
   logic [3:0] vout_fault = 4'h0;
   logic [3:0] iout_fault = 4'h0;
   logic [3:0] ramp_busy = 4'h0;
   logic overheat = 1'h0;
   logic fault_alarm_n;
   logic [3:0] ramp_enable;
   logic [31:0] rx;
   int n_errors = 0;
   int n_tests = 0;

   always #25 hclk = ~hclk;

   qdr_link_if qdr_link_if_i ();
   qdr_host qdr_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .link(qdr_link_if_i.host));
   qdr_device qdr_device_i (.hclk(hclk), .hresetn(hresetn),
      .link(qdr_link_if_i.dev), .limit_event(limit_event),
      .current_mode(current_mode), .vout_fault(vout_fault),
      .iout_fault(iout_fault), .overheat(overheat), .ramp_busy(ramp_busy),
      .chip_addr_hi(ADR[1]), .chip_addr_lo(ADR[0]),
      .fault_alarm_n(fault_alarm_n), .ramp_enable(ramp_enable));
   qdr_link_properties qdr_link_properties_i (.hclk(hclk),
      .hresetn(hresetn), .sclk(qdr_link_if_i.sclk),
      .sync_n(qdr_link_if_i.sync_n), .sdin(qdr_link_if_i.sdin),
      .sdo(qdr_link_if_i.sdo));

   function automatic logic [23:0] wr_w(input logic [4:0] s,
                                        input logic [15:0] d);
      return {1'h0, ADR, s, d};
   endfunction : wr_w

   function automatic logic [23:0] rd_w(input logic [4:0] s);
      return {1'h1, ADR, s, 16'hffff};
   endfunction : rd_w

   // Distinct pattern per select; slew words keep their fixed zeros
   function automatic logic [15:0] dat(input int i);
      logic [4:0] k;
      k = 5'(i);
      return {((i < 20) ? 3'h5 : 3'h0), 1'(i == 20), ~k[3:0], 3'h3, k};
   endfunction : dat

   function automatic logic [7:0] crc(input logic [23:0] w);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         r = {r[6:0], 1'h0} ^ (((r[7] ^ w[i]) == 1'h1) ? 8'h07 : 8'h00);
      end
      return r;
   endfunction : crc

   function automatic logic [15:0] st(input logic chk);
      return {limit_event, chk, 1'h0, |(ramp_busy & 4'h1), overheat,
              vout_fault, iout_fault | (limit_event & current_mode)};
   endfunction : st

   task automatic ahb(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask : ahb

   // Send one word, wait for the link to go idle, fetch what came back
   task automatic frame(input logic [23:0] w);
      logic [31:0] s;
      int n;
      ahb(1'h1, qdr_pkg::HOST_TX_OFS, {8'h00, w}, s);
      n = 0;
      s = 32'h0000_0001;
      while (s[0] !== 1'h0 && n < 500) begin
         ahb(1'h0, qdr_pkg::HOST_STAT_OFS, 32'h0000_0000, s);
         n++;
      end
      `CHK({hresp, s[1:0]}, 3'h0)
      ahb(1'h0, qdr_pkg::HOST_RX_OFS, 32'h0000_0000, rx);
   endtask : frame

   task automatic test_done;
      $display("errors %0d, comparisons %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   initial begin
      #3_000_000;
      n_errors++;
      test_done();
   end

   initial begin
      logic [31:0] v;
      repeat (8) @(posedge hclk);
      hresetn <= 1'h1;
      repeat (4) @(posedge hclk);
      for (int a = 0; a < 5; a++) begin
         ahb(1'h0, 32'(a * 4), 32'h0000_0000, v);
         `CHK(v, 32'h0000_0000)
      end
      for (int i = 0; i < 24; i++) begin
         frame(wr_w(5'(i), dat(i)));
      end
      frame(wr_w(5'h15, 16'he000 | dat(21)));
      frame({1'h0, ~ADR, 5'h08, 16'h0bad});
      `CHK(ramp_enable, 4'h1)
      // Chained reads: each frame returns the select asked one frame before
      frame(rd_w(5'h00));
      for (int i = 1; i <= 24; i++) begin
         frame((i < 24) ? rd_w(5'(i)) : qdr_pkg::NO_OPERATION_WORD);
         `CHK(rx[15:0], dat(i - 1))
      end
      `CHK(rx[23:16], 8'h00)
      @(posedge hclk);
      limit_event <= 4'ha;
      ramp_busy <= 4'h2;
      frame(wr_w(5'h18, 16'hffff));
      frame(rd_w(5'h18));
      `CHK(rx[23:0], 24'h00_0000)
      frame(qdr_pkg::NO_OPERATION_WORD);
      `CHK(rx[15:0], st(1'h0))
      `CHK(fault_alarm_n, 1'h1)
      @(posedge hclk);
      limit_event <= 4'h5;
      current_mode <= 4'h1;
      vout_fault <= 4'h8;
      iout_fault <= 4'h2;
      overheat <= 1'h1;
      ramp_busy <= 4'h3;
      frame(wr_w(5'h19, 16'h0800));
      frame(wr_w(5'h1a, 16'h0abc));
      `CHK(rx[15:0], st(1'h0))
      `CHK(fault_alarm_n, 1'h0)
      frame(rd_w(5'h1a));
      frame(rd_w(5'h19));
      `CHK(rx[15:0], 16'h0abc)
      frame(qdr_pkg::NO_OPERATION_WORD);
      `CHK(rx[15:0], 16'h0800)
      frame(wr_w(5'h19, 16'h1800));
      ahb(1'h1, qdr_pkg::HOST_CFG_OFS, 32'h0000_0001, v);
      frame(rd_w(5'h18));
      frame(qdr_pkg::NO_OPERATION_WORD);
      `CHK(rx, {8'h00, st(1'h1), crc({8'h00, st(1'h1)})})
      `CHK(rx[23:8], {limit_event, 4'hb, vout_fault, 4'h3})
      test_done();
   end
endmodule : tb_top
